//--- inc/tbpc_regs.svh
// Register offsets, field positions, reset values and sequence constants of the test port block.
`ifndef TBPC_REGS_SVH
`define TBPC_REGS_SVH

// ==========================================================
// Register offsets
`define TBPC_ADDR_TIMER_HI   8'h2E
`define TBPC_ADDR_TIMER_LO   8'h2F
`define TBPC_ADDR_RESERVED   8'h30
`define TBPC_ADDR_BIT_SEL    8'h31
`define TBPC_ADDR_BUS_CFG    8'h32
`define TBPC_ADDR_PIN_EN     8'h33
`define TBPC_ADDR_PIN_VAL    8'h34
`define TBPC_ADDR_TEST_BUS   8'h35

// ==========================================================
// Reset values
`define TBPC_RST_RESERVED    8'h00
`define TBPC_RST_BIT_SEL     8'h00
`define TBPC_RST_BUS_CFG     8'h00
`define TBPC_RST_PIN_EN      8'h80
`define TBPC_RST_PIN_VAL     8'h00

// ==========================================================
// Field positions
`define TBPC_BIT_SEL_FIELD   2:0
`define TBPC_BUS_SEL_FIELD   4:0
`define TBPC_FLIP_BIT        7
`define TBPC_PRBS_NINE_ENABLE_BIT       6
`define TBPC_PRBS_FIFTEEN_ENABLE_BIT      5
`define TBPC_LINE_EN_BIT     7
`define TBPC_IO_USE_BIT      7
`define TBPC_PIN_FIELD       6:1

// ==========================================================
// Codes and sequence constants
`define TBPC_AUX_INTERNAL_TEST_BUS_VALUE     4'hF
`define TBPC_PRBS_SEED       15'h7FFF

`endif

//--- inc/tbpc_pkg.sv
// Types shared by the test port block and its sequence generator.
package tbpc_pkg;

  typedef logic [7:0] tbpc_byte_t;

  typedef enum logic [0:0] {
    TBPC_PRBS_IDLE = 1'b0,
    TBPC_PRBS_RUN  = 1'b1
  } tbpc_prbs_state_e;

  typedef struct packed {
    tbpc_prbs_state_e state;
    logic             is_nine;
    logic [14:0]      lfsr;
    logic             data;
  } tbpc_prbs_s;

  typedef struct packed {
    logic [2:0]  bit_sel;
    tbpc_byte_t  bus_cfg;
    tbpc_byte_t  pin_en;
    tbpc_byte_t  pin_val;
    tbpc_byte_t  rdata;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  pin_live;
    logic        multifunction_output_pin;
    logic        aux;
    logic        aux_oe;
    logic [5:0]  port_out;
    logic [5:0]  port_oe;
  } tbpc_top_s;

endpackage : tbpc_pkg

//--- core/tbpc_prbs.sv
// Pseudo-random transmit sequence generator with nine and fifteen stage modes.
`timescale 1ns/1ps
`include "tbpc_regs.svh"

module tbpc_prbs (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Control
  input  wire logic nine_enable_in,
  input  wire logic fifteen_enable_in,
  input  wire logic transmit_command_in,
  input  wire logic bit_step_in,
  // Sequence
  output logic      data_out,
  output logic      active_out
);
  import tbpc_pkg::*;

  tbpc_prbs_s q;
  tbpc_prbs_s next_q;
  logic       fb;

  // ==========================================================
  // Sequence engine
  always_comb begin
    next_q = q;
    fb     = q.is_nine ? (q.lfsr[8] ^ q.lfsr[4]) : (q.lfsr[14] ^ q.lfsr[13]);
    case (q.state)
      TBPC_PRBS_IDLE: begin
        // The enable alone only arms the generator; the transmit command starts it.
        if (transmit_command_in && (nine_enable_in || fifteen_enable_in)) begin
          next_q.state   = TBPC_PRBS_RUN;
          next_q.is_nine = nine_enable_in;
          next_q.lfsr    = `TBPC_PRBS_SEED;
        end
      end
      TBPC_PRBS_RUN: begin
        if (!nine_enable_in && !fifteen_enable_in) begin
          next_q.state = TBPC_PRBS_IDLE;
        end else if (bit_step_in) begin
          next_q.data = fb;
          if (q.is_nine) begin
            next_q.lfsr = {6'h00, q.lfsr[7:0], fb};
          end else begin
            next_q.lfsr = {q.lfsr[13:0], fb};
          end
        end
      end
      default: next_q.state = TBPC_PRBS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign data_out   = q.data;
  assign active_out = (q.state == TBPC_PRBS_RUN);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_prbs_no_self_start: assert property (
    (q.state == TBPC_PRBS_IDLE) && !transmit_command_in |=> (q.state == TBPC_PRBS_IDLE))
    else $error("sequence started without transmit command");
  a_prbs_nine_taps: assert property (
    active_out && q.is_nine && bit_step_in && nine_enable_in |=> data_out == ($past(q.lfsr[8]) ^ $past(q.lfsr[4])))
    else $error("nine stage feedback wrong");
  a_prbs_fifteen_taps: assert property (
    active_out && !q.is_nine && bit_step_in && fifteen_enable_in |=>
      data_out == ($past(q.lfsr[14]) ^ $past(q.lfsr[13])))
    else $error("fifteen stage feedback wrong");
  c_prbs_nine_run: cover property (transmit_command_in && nine_enable_in ##1 active_out ##1 bit_step_in);
  c_prbs_fifteen_run: cover property (transmit_command_in && fifteen_enable_in && !nine_enable_in ##1 active_out);

endmodule : tbpc_prbs

//--- core/tbpc_top.sv
// Test bus routing, test port and transmit sequence control with its register slave.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "tbpc_regs.svh"

module tbpc_top (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // Register port
  input  wire tbpc_pkg::tbpc_byte_t reg_addr_in,
  input  wire tbpc_pkg::tbpc_byte_t reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output tbpc_pkg::tbpc_byte_t      reg_rdata_out,
  // Internal sources
  input  wire logic [255:0]         internal_test_bus_value_in,
  input  wire logic [15:0]          timer_count_in,
  input  wire logic [3:0]           auxiliary_pin_two_analog_select_in,
  input  wire logic                 serial_host_active_in,
  // Transmitter
  input  wire logic                 transmit_command_in,
  input  wire logic                 tx_bit_step_in,
  output logic                      prbs_data_out,
  output logic                      prbs_active_out,
  // Pins
  output logic                      multifunction_output_pin_out,
  output logic                      auxiliary_pin_two_out,
  output logic                      auxiliary_pin_two_oe_out,
  output logic                      uart_line_a_enable_out,
  output logic                      uart_line_b_enable_out,
  input  wire logic [5:0]           test_port_in,
  output logic [5:0]                test_port_out,
  output logic [5:0]                test_port_oe_out
);
  import tbpc_pkg::*;

  tbpc_top_s  q;
  tbpc_top_s  next_q;
  tbpc_byte_t cur_bus;
  logic       cur_bit;
  logic       io_mode;
  logic [5:0] port_src;

  // ==========================================================
  // Test bus selection
  assign cur_bus = internal_test_bus_value_in[q.bus_cfg[`TBPC_BUS_SEL_FIELD] * 8 +: 8];
  assign cur_bit = cur_bus[q.bit_sel];
  // The port only drives I/O levels while a serial host interface owns the data pins; reads of live pins need only the IO use bit.
  assign io_mode = q.pin_val[`TBPC_IO_USE_BIT] && serial_host_active_in;

  // ==========================================================
  // Port bit order, pin D1 at index 0
  localparam int unsigned FLIP_SRC [6] = '{0, 5, 6, 2, 3, 4};

  generate
    for (genvar i = 0; i < 6; i++) begin : g_port
      assign port_src[i] = q.bus_cfg[`TBPC_FLIP_BIT] ? cur_bus[FLIP_SRC[i]] : cur_bus[i];
    end
  endgenerate

  // ==========================================================
  // Register slave and pin logic
  always_comb begin
    next_q = q;
    // Middle and last stages are compared; the first stage feeds nothing else.
    next_q.sync1 = test_port_in;
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    if (q.sync2 == q.sync3) begin
      next_q.pin_live = q.sync3;
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        `TBPC_ADDR_BIT_SEL: next_q.bit_sel = reg_wdata_in[`TBPC_BIT_SEL_FIELD];
        `TBPC_ADDR_BUS_CFG: next_q.bus_cfg = reg_wdata_in;
        `TBPC_ADDR_PIN_EN:  next_q.pin_en  = {reg_wdata_in[7:1], 1'b0};
        `TBPC_ADDR_PIN_VAL: next_q.pin_val = {reg_wdata_in[7:1], 1'b0};
        default: next_q.bit_sel = q.bit_sel;
      endcase
    end

    next_q.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TBPC_ADDR_TIMER_HI: next_q.rdata = timer_count_in[15:8];
        `TBPC_ADDR_TIMER_LO: next_q.rdata = timer_count_in[7:0];
        `TBPC_ADDR_RESERVED: next_q.rdata = `TBPC_RST_RESERVED;
        `TBPC_ADDR_BIT_SEL:  next_q.rdata = {5'h00, q.bit_sel};
        `TBPC_ADDR_BUS_CFG:  next_q.rdata = q.bus_cfg;
        `TBPC_ADDR_PIN_EN:   next_q.rdata = q.pin_en;
        `TBPC_ADDR_PIN_VAL: begin
          if (q.pin_val[`TBPC_IO_USE_BIT]) begin
            next_q.rdata = {1'b1, q.pin_live, 1'b0};
          end else begin
            next_q.rdata = q.pin_val;
          end
        end
        `TBPC_ADDR_TEST_BUS: next_q.rdata = cur_bus;
        default:             next_q.rdata = 8'h00;
      endcase
    end

    next_q.multifunction_output_pin  = cur_bit;
    next_q.aux    = cur_bit;
    next_q.aux_oe = (auxiliary_pin_two_analog_select_in == `TBPC_AUX_INTERNAL_TEST_BUS_VALUE);
    next_q.port_oe = q.pin_en[`TBPC_PIN_FIELD];
    if (io_mode) begin
      next_q.port_out = q.pin_val[`TBPC_PIN_FIELD];
    end else begin
      next_q.port_out = port_src;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q         <= '0;
      q.bit_sel <= 3'h0;
      q.bus_cfg <= `TBPC_RST_BUS_CFG;
      q.pin_en  <= `TBPC_RST_PIN_EN;
      q.pin_val <= `TBPC_RST_PIN_VAL;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Sequence generator
  tbpc_prbs u_prbs (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .nine_enable_in      (q.bus_cfg[`TBPC_PRBS_NINE_ENABLE_BIT]),
    .fifteen_enable_in   (q.bus_cfg[`TBPC_PRBS_FIFTEEN_ENABLE_BIT]),
    .transmit_command_in (transmit_command_in),
    .bit_step_in         (tx_bit_step_in),
    .data_out            (prbs_data_out),
    .active_out          (prbs_active_out)
  );

  // ==========================================================
  // Outputs
  assign reg_rdata_out                = q.rdata;
  assign multifunction_output_pin_out = q.multifunction_output_pin;
  assign auxiliary_pin_two_out        = q.aux;
  assign auxiliary_pin_two_oe_out     = q.aux_oe;
  assign uart_line_a_enable_out       = q.pin_en[`TBPC_LINE_EN_BIT];
  assign uart_line_b_enable_out       = q.pin_en[`TBPC_LINE_EN_BIT];
  assign test_port_out                = q.port_out;
  assign test_port_oe_out             = q.port_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_multifunction_output_pin_bit_select: assert property (
    1'b1 |=> multifunction_output_pin_out == $past(cur_bit))
    else $error("multifunction output is not the selected bit");

  a_aux_drive_code: assert property (
    auxiliary_pin_two_analog_select_in == `TBPC_AUX_INTERNAL_TEST_BUS_VALUE |=> auxiliary_pin_two_oe_out && auxiliary_pin_two_out == $past(cur_bit))
    else $error("aux pin not driven with test bit");

  a_bus_status_read: assert property (
    reg_rd_in && reg_addr_in == `TBPC_ADDR_TEST_BUS |=> reg_rdata_out == $past(cur_bus))
    else $error("test bus status read wrong");

  a_bus_select_path: assert property (
    reg_wr_in && reg_addr_in == `TBPC_ADDR_BUS_CFG ##1 reg_rd_in && reg_addr_in == `TBPC_ADDR_TEST_BUS |=>
      reg_rdata_out == $past(cur_bus) && $past(q.bus_cfg[`TBPC_BUS_SEL_FIELD]) == $past(reg_wdata_in[4:0], 2))
    else $error("bus select not applied");

  a_flip_order: assert property (
    q.bus_cfg[`TBPC_FLIP_BIT] && !io_mode |=> test_port_out[0] == $past(cur_bus[0]) &&
      test_port_out[2] == $past(cur_bus[6]) && test_port_out[5] == $past(cur_bus[4]))
    else $error("flipped port order wrong");

  a_uart_line_enable: assert property (
    reg_wr_in && reg_addr_in == `TBPC_ADDR_PIN_EN |=> uart_line_a_enable_out == $past(reg_wdata_in[7]) &&
      uart_line_b_enable_out == $past(reg_wdata_in[7]))
    else $error("uart line enable not following write");

  a_pin_enable_map: assert property (
    reg_wr_in && reg_addr_in == `TBPC_ADDR_PIN_EN |=> ##1 test_port_oe_out == $past(reg_wdata_in[6:1], 2))
    else $error("pin driver enable mismatch");

  a_io_value_drive: assert property (
    io_mode |=> test_port_out == $past(q.pin_val[6:1]))
    else $error("io mode drives wrong level");

  a_pin_value_read: assert property (
    reg_rd_in && reg_addr_in == `TBPC_ADDR_PIN_VAL && q.pin_val[7] |=> reg_rdata_out[6:1] == $past(q.pin_live))
    else $error("live pin read wrong");

  a_timer_low_read: assert property (
    reg_rd_in && reg_addr_in == `TBPC_ADDR_TIMER_LO |=> reg_rdata_out == $past(timer_count_in[7:0]))
    else $error("timer low byte wrong");

  a_timer_high_read: assert property (
    reg_rd_in && reg_addr_in == `TBPC_ADDR_TIMER_HI |=> reg_rdata_out == $past(timer_count_in[15:8]))
    else $error("timer high byte wrong");

  a_reserved_reads_zero: assert property (
    reg_rd_in && reg_addr_in == `TBPC_ADDR_RESERVED |=> reg_rdata_out == 8'h00)
    else $error("reserved slot not zero");

  a_reserved_bits_zero: assert property (
    reg_rd_in && (reg_addr_in == `TBPC_ADDR_BIT_SEL || reg_addr_in == `TBPC_ADDR_PIN_EN) |=>
      (($past(reg_addr_in) == `TBPC_ADDR_PIN_EN) ? (reg_rdata_out[0] == 1'b0) : (reg_rdata_out[7:3] == 5'h00)))
    else $error("reserved bits not zero");

  a_write_next_edge: assert property (
    reg_wr_in && reg_addr_in == `TBPC_ADDR_BUS_CFG ##1 reg_rd_in && reg_addr_in == `TBPC_ADDR_BUS_CFG |=>
      reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("write not visible on next edge");

  c_flip_port: cover property (q.bus_cfg[`TBPC_FLIP_BIT] && |test_port_oe_out);
  c_io_read: cover property (io_mode && reg_rd_in && reg_addr_in == `TBPC_ADDR_PIN_VAL);
  c_aux_drive: cover property (auxiliary_pin_two_oe_out ##1 multifunction_output_pin_out);

endmodule : tbpc_top

//--- test/tbpc_pin_model.sv
// Model of the test equipment that sits on the data pins of the test port.
`timescale 1ns/1ps

module tbpc_pin_model (
  // Device side
  input  wire logic [5:0] port_out_in,
  input  wire logic [5:0] port_oe_in,
  // Tester side
  input  wire logic [5:0] ext_level_in,
  output logic [5:0]      port_in_out
);
  // The tester drives every pin that the device leaves undriven, so no pin ever floats.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      port_in_out[i] = port_oe_in[i] ? port_out_in[i] : ext_level_in[i];
    end
  end
endmodule : tbpc_pin_model

//--- test/tb_tbpc_top.sv
// Self-checking testbench for the test bus and test port control block.
`timescale 1ns/1ps
`include "tbpc_regs.svh"

module tb_tbpc_top;
  import tbpc_pkg::*;
  // ==========================================================
  // Signals
  logic         clk_in, resetn_in, reg_wr, reg_rd, host_act, tx_cmd, tx_step;
  tbpc_byte_t   reg_addr, reg_wdata, reg_rdata;
  logic [255:0] bus;
  logic [15:0]  timer;
  logic [3:0]   aux_sel;
  logic [5:0]   ext_level, port_in, port_out, port_oe;
  logic         prbs_data, prbs_active, multifunction_output_pin, aux, aux_oe, uart_a, uart_b;
  int           n_mismatch, n_compared, cycles;
  tbpc_byte_t   b;
  logic [14:0]  s;
  logic         fb;

  tbpc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .internal_test_bus_value_in(bus),
    .timer_count_in(timer), .auxiliary_pin_two_analog_select_in(aux_sel), .serial_host_active_in(host_act),
    .transmit_command_in(tx_cmd), .tx_bit_step_in(tx_step), .prbs_data_out(prbs_data),
    .prbs_active_out(prbs_active), .multifunction_output_pin_out(multifunction_output_pin), .auxiliary_pin_two_out(aux),
    .auxiliary_pin_two_oe_out(aux_oe), .uart_line_a_enable_out(uart_a), .uart_line_b_enable_out(uart_b),
    .test_port_in(port_in), .test_port_out(port_out), .test_port_oe_out(port_oe));

  tbpc_pin_model pins (.port_out_in(port_out), .port_oe_in(port_oe), .ext_level_in(ext_level),
    .port_in_out(port_in));

  // ==========================================================
  // Tasks
  function automatic tbpc_byte_t bb(input int k);
    return 8'(k * 37 + 11);
  endfunction : bb

  task automatic chk(input tbpc_byte_t got, input tbpc_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input tbpc_byte_t a, input tbpc_byte_t d);
    @(posedge clk_in) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clk_in) reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input tbpc_byte_t a, input tbpc_byte_t exp);
    @(posedge clk_in) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge clk_in) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  // Write then read with no gap, so the read shows whether the write landed at the very next edge.
  task automatic wr_rd_chk(input tbpc_byte_t wa, input tbpc_byte_t d, input tbpc_byte_t ra, input tbpc_byte_t exp);
    @(posedge clk_in) begin reg_addr <= wa; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clk_in) begin reg_wr <= 1'b0; reg_addr <= ra; reg_rd <= 1'b1; end
    @(posedge clk_in) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : wr_rd_chk

  // Pin outputs trail a write by one extra register stage, so three edges are ample.
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic pulse_cmd();
    @(posedge clk_in) tx_cmd <= 1'b1;
    @(posedge clk_in) tx_cmd <= 1'b0;
    #1;
  endtask : pulse_cmd

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Clock, timeout and sequence
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {resetn_in, reg_wr, reg_rd, host_act, tx_cmd, tx_step} = 6'h00;
    {reg_addr, reg_wdata, aux_sel, ext_level} = 26'h000_0000;
    n_mismatch = 0;
    n_compared = 0;
    cycles     = 0;
    timer = 16'hA55A;
    for (int k = 0; k < 32; k++) bus[8*k +: 8] = bb(k);
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    rd_chk(`TBPC_ADDR_RESERVED, 8'h00);
    rd_chk(`TBPC_ADDR_BIT_SEL, 8'h00);
    rd_chk(`TBPC_ADDR_BUS_CFG, 8'h00);
    rd_chk(`TBPC_ADDR_PIN_EN, 8'h80);
    rd_chk(`TBPC_ADDR_PIN_VAL, 8'h00);
    chk({6'h00, uart_a, uart_b}, 8'h03);
    rd_chk(`TBPC_ADDR_TIMER_LO, 8'h5A);
    rd_chk(`TBPC_ADDR_TIMER_HI, 8'hA5);
    $display("test reset values done");
    wr_reg(`TBPC_ADDR_RESERVED, 8'hFF);
    wr_reg(`TBPC_ADDR_BIT_SEL, 8'hFF);
    wr_reg(`TBPC_ADDR_TIMER_LO, 8'h00);
    wr_reg(`TBPC_ADDR_PIN_EN, 8'hFF);
    rd_chk(`TBPC_ADDR_RESERVED, 8'h00);
    rd_chk(`TBPC_ADDR_BIT_SEL, 8'h07);
    rd_chk(`TBPC_ADDR_TIMER_LO, 8'h5A);
    rd_chk(`TBPC_ADDR_PIN_EN, 8'hFE);
    rd_chk(8'h10, 8'h00);
    $display("test reserved and read-only done");
    @(posedge clk_in) aux_sel <= 4'hF;
    for (int k = 3; k < 32; k += 28) begin
      wr_rd_chk(`TBPC_ADDR_BUS_CFG, 8'(k), `TBPC_ADDR_TEST_BUS, bb(k));
      b = bb(k);
      for (int i = 0; i < 8; i++) begin
        wr_reg(`TBPC_ADDR_BIT_SEL, 8'(i));
        settle();
        chk({7'h00, multifunction_output_pin}, {7'h00, b[i]});
        chk({6'h00, aux_oe, aux}, {6'h00, 1'b1, b[i]});
      end
    end
    @(posedge clk_in) aux_sel <= 4'h0;
    settle();
    chk({7'h00, aux_oe}, 8'h00);
    $display("test bus routing done");
    b = bb(31);
    wr_reg(`TBPC_ADDR_PIN_EN, 8'h7E);
    settle();
    chk({2'b00, port_oe}, 8'h3F);
    chk({2'b00, port_out}, {2'b00, b[5:0]});
    chk({6'h00, uart_a, uart_b}, 8'h00);
    wr_reg(`TBPC_ADDR_BUS_CFG, 8'h9F);
    settle();
    chk({2'b00, port_out}, {2'b00, b[4], b[3], b[2], b[6], b[5], b[0]});
    wr_reg(`TBPC_ADDR_PIN_EN, 8'h0A);
    settle();
    chk({2'b00, port_oe}, 8'h05);
    $display("test port mapping done");
    @(posedge clk_in) begin host_act <= 1'b1; ext_level <= 6'b010110; end
    wr_reg(`TBPC_ADDR_PIN_EN, 8'h9E);
    wr_reg(`TBPC_ADDR_PIN_VAL, 8'hDA);
    settle();
    chk({2'b00, port_oe}, 8'h0F);
    chk({2'b00, port_out & port_oe}, 8'h0D);
    settle();
    rd_chk(`TBPC_ADDR_PIN_VAL, 8'hBA);
    wr_reg(`TBPC_ADDR_PIN_VAL, 8'h5A);
    rd_chk(`TBPC_ADDR_PIN_VAL, 8'h5A);
    $display("test general io done");
    wr_rd_chk(`TBPC_ADDR_BUS_CFG, 8'h00, `TBPC_ADDR_BUS_CFG, 8'h00);
    pulse_cmd();
    chk({7'h00, prbs_active}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr_reg(`TBPC_ADDR_BUS_CFG, m ? 8'h20 : 8'h40);
      settle();
      chk({7'h00, prbs_active}, 8'h00);
      pulse_cmd();
      chk({7'h00, prbs_active}, 8'h01);
      s = 15'h7FFF;
      for (int i = 0; i < 24; i++) begin
        fb = m ? s[14] ^ s[13] : s[8] ^ s[4];
        s = {s[13:0], fb};
        @(posedge clk_in) tx_step <= 1'b1;
        @(posedge clk_in) tx_step <= 1'b0;
        #1;
        chk({7'h00, prbs_data}, {7'h00, fb});
      end
      wr_reg(`TBPC_ADDR_BUS_CFG, 8'h00);
      settle();
      chk({7'h00, prbs_active}, 8'h00);
    end
    $display("test sequence generator done");
    finish_test();
  end
endmodule : tb_tbpc_top
